/* File: hw/fan_ctrl_pkg.sv */
// constants, register map and types for the thermal fan duty controller
package fan_ctrl_pkg;
   // clock and time base
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned SAMPLE_PERIOD_MS = 1000;
   localparam int unsigned SEC_CYCLES       = SAMPLE_PERIOD_MS * (1_000_000 / CLK_PERIOD_NS);
   localparam int unsigned PWM_HZ           = 32;
   localparam int unsigned DUTY_STEPS       = 64;
   localparam int unsigned PWM_SLOT_CYCLES  = CLK_HZ / (PWM_HZ * DUTY_STEPS);
   localparam int unsigned FAN_EVAL_SECS    = 4;
   localparam int unsigned FAULT_WIN_SECS   = 2;
   localparam int unsigned TACH_MIN_PULSES  = 32;
   localparam int unsigned START_DELAY_SECS = 2;
   localparam int unsigned SPINUP_SECS      = 2;
   localparam int unsigned START_DUTY_STEPS = 19;
   localparam int unsigned MIN_DUTY_MAX     = 25;

   // threshold tables: base + step * (3 * hi_code + lo_code)
   localparam logic [7:0] UPPER_BASE_C = 8'h14;
   localparam logic [7:0] LOWER_BASE_C = 8'h0f;
   localparam logic [7:0] ALARM_BASE_C = 8'h3c;
   localparam logic [7:0] LIMIT_STEP_C = 8'h05;

   // three-state select pin codes
   localparam logic [1:0] SEL_LOW  = 2'h0;
   localparam logic [1:0] SEL_OPEN = 2'h1;
   localparam logic [1:0] SEL_HIGH = 2'h2;

   // register map, byte addresses
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] TEMP_OFS   = 8'h08;

   // field positions
   localparam int unsigned CTRL_MODE_LSB   = 0;
   localparam int unsigned CTRL_CLEAR_BIT  = 8;
   localparam int unsigned STAT_STATE_LSB  = 8;
   localparam int unsigned STAT_HOT_BIT    = 16;
   localparam int unsigned STAT_FAULT_BIT  = 17;
   localparam int unsigned STAT_FULL_BIT   = 18;

   typedef enum logic [1:0] {
      SENSE_TACH   = 2'b00,
      SENSE_LOCKED = 2'b01,
      SENSE_OFF    = 2'b10
   } sense_mode_t;
   localparam sense_mode_t CTRL_MODE_RST = SENSE_TACH;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_SPIN = 2'b01,
      ST_RUN  = 2'b10,
      ST_OFF  = 2'b11
   } fan_state_t;
endpackage

/* File: hw/thermal_fan_duty_controller.sv */
// temperature driven fan pwm duty controller with alarms and ahb-lite registers
module thermal_fan_duty_controller
   import fan_ctrl_pkg::*;
#(
   parameter int unsigned SEC_CYC    = fan_ctrl_pkg::SEC_CYCLES,
   parameter int unsigned SLOT_CYC   = fan_ctrl_pkg::PWM_SLOT_CYCLES,
   parameter int unsigned WAIT_SECS  = fan_ctrl_pkg::START_DELAY_SECS,
   parameter int unsigned SPIN_SECS  = fan_ctrl_pkg::SPINUP_SECS,
   parameter bit          START_OPT  = 1'b0,
   parameter int unsigned START_DUTY = fan_ctrl_pkg::START_DUTY_STEPS
) (
   // clock, reset, enable
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [7:0]  haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   // temperature front end, same clock
   input  wire logic [7:0]  temp_a_i,
   input  wire logic        temp_a_bad_i,
   input  wire logic [7:0]  temp_b_i,
   input  wire logic        temp_b_bad_i,
   // three-state select pins, asynchronous
   input  wire logic [1:0]  upper_limit_sel_lo_i,
   input  wire logic [1:0]  upper_limit_sel_hi_i,
   input  wire logic [1:0]  lower_limit_sel_lo_i,
   input  wire logic [1:0]  lower_limit_sel_hi_i,
   input  wire logic [1:0]  alarm_limit_sel_lo_i,
   input  wire logic [1:0]  alarm_limit_sel_hi_i,
   // fan sense pins, asynchronous
   input  wire logic        fan_sense_in_a_i,
   input  wire logic        fan_sense_in_b_i,
   // fan drive and alarms
   output logic             pwm_out_o,
   output logic             overheat_alarm_n_o,
   output logic             overheat_alarm_n_oe_o,
   output logic             fan_fault_alarm_n_o,
   output logic             fan_fault_alarm_n_oe_o
);
   import fan_ctrl_pkg::*;

   localparam int unsigned SW = $clog2(SEC_CYC);
   localparam int unsigned PW = (SLOT_CYC > 1) ? $clog2(SLOT_CYC) : 1;
   localparam logic [6:0]  FULL_DUTY = 7'(DUTY_STEPS);
   localparam logic [6:0]  START_D   = 7'(START_DUTY);
   localparam logic [6:0]  FLOOR_D   = START_OPT ? 7'(START_DUTY) : 7'h00;

   if (SEC_CYC < 4 || SLOT_CYC < 1 || WAIT_SECS < 1 || WAIT_SECS > 15 ||
       SPIN_SECS < 1 || SPIN_SECS > 15 || START_DUTY > MIN_DUTY_MAX) begin : g_bad_param
      $error("thermal_fan_duty_controller: parameter out of range");
   end

   // ---------------- time base ----------------
   logic [SW-1:0] sec_cnt_reg;
   logic [1:0]    quad_cnt_reg;
   wire           sec_tick  = ce_i && (sec_cnt_reg == SW'(SEC_CYC - 1));
   wire           eval_tick = sec_tick && (quad_cnt_reg == 2'(FAN_EVAL_SECS - 1));

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         sec_cnt_reg  <= '0;
         quad_cnt_reg <= '0;
      end else if (ce_i) begin
         sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + SW'(1);
         if (sec_tick) begin
            quad_cnt_reg <= quad_cnt_reg + 2'h1;
         end
      end
   end

   // ---------------- select pins ----------------
   // hold codes in two flops; pins are straps but may still move
   logic [11:0] sel_s1_reg;
   logic [11:0] sel_s2_reg;
   wire  [11:0] sel_raw = {alarm_limit_sel_hi_i, alarm_limit_sel_lo_i,
                           lower_limit_sel_hi_i, lower_limit_sel_lo_i,
                           upper_limit_sel_hi_i, upper_limit_sel_lo_i};

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         sel_s1_reg <= '0;
         sel_s2_reg <= '0;
      end else if (ce_i) begin
         sel_s1_reg <= sel_raw;
         sel_s2_reg <= sel_s1_reg;
      end
   end

   function automatic logic [7:0] limit_of(input logic [1:0] hi, input logic [1:0] lo,
                                           input logic [7:0] base);
      logic [3:0] idx;
      logic [3:0] h;
      logic [3:0] l;
      h   = (hi == SEL_LOW) ? 4'h0 : (hi == SEL_OPEN) ? 4'h1 : 4'h2;
      l   = (lo == SEL_LOW) ? 4'h0 : (lo == SEL_OPEN) ? 4'h1 : 4'h2;
      idx = 4'(h * 4'h3) + l;
      return base + 8'(idx * LIMIT_STEP_C);
   endfunction

   wire [7:0] upper_fan_limit = limit_of(sel_s2_reg[3:2], sel_s2_reg[1:0],
                                         UPPER_BASE_C);
   wire [7:0] lower_fan_limit = limit_of(sel_s2_reg[7:6], sel_s2_reg[5:4],
                                         LOWER_BASE_C);
   wire [7:0] alarm_limit     = limit_of(sel_s2_reg[11:10], sel_s2_reg[9:8],
                                         ALARM_BASE_C);

   // ---------------- temperature ----------------
   wire [7:0] eff_a    = temp_a_bad_i ? 8'h00 : temp_a_i;
   wire [7:0] eff_b    = temp_b_bad_i ? 8'h00 : temp_b_i;
   wire [7:0] temp_now = (eff_a > eff_b) ? eff_a : eff_b;
   logic [7:0] temp_reg;
   logic       hot_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         temp_reg <= 8'h00;
         hot_reg  <= 1'b0;
      end else if (sec_tick) begin
         temp_reg <= temp_now;
         if (temp_now > alarm_limit) begin
            hot_reg <= 1'b1;
         end else if (temp_now < alarm_limit) begin
            hot_reg <= 1'b0;
         end
      end
   end

   // ---------------- duty state machine ----------------
   fan_state_t state_reg;
   fan_state_t state_next;
   logic [6:0] duty_reg;
   logic [6:0] duty_next;
   logic [3:0] phase_reg;
   logic [3:0] phase_next;
   wire        above_upper = temp_now > upper_fan_limit;
   wire        below_lower = temp_now < lower_fan_limit;
   wire        full_duty   = duty_reg == FULL_DUTY;

   always_comb begin
      state_next = state_reg;
      duty_next  = duty_reg;
      phase_next = phase_reg;
      case (state_reg)
         ST_WAIT: begin
            duty_next = 7'h00;
            if (sec_tick) begin
               phase_next = phase_reg + 4'h1;
               if (phase_reg == 4'(WAIT_SECS - 1)) begin
                  state_next = ST_SPIN;
                  duty_next  = FULL_DUTY;
                  phase_next = 4'h0;
               end
            end
         end
         ST_SPIN: begin
            duty_next = FULL_DUTY;
            if (sec_tick) begin
               phase_next = phase_reg + 4'h1;
               if (phase_reg == 4'(SPIN_SECS - 1)) begin
                  state_next = ST_RUN;
                  duty_next  = START_D;
                  phase_next = 4'h0;
               end
            end
         end
         ST_RUN: begin
            if (eval_tick) begin
               if (above_upper) begin
                  if (!full_duty) begin
                     duty_next = duty_reg + 7'h01;
                  end
               end else if (below_lower && duty_reg > FLOOR_D) begin
                  duty_next = duty_reg - 7'h01;
                  if (!START_OPT && duty_reg == 7'h01) begin
                     state_next = ST_OFF;
                  end
               end
            end
         end
         ST_OFF: begin
            duty_next = 7'h00;
            if (eval_tick && above_upper) begin
               state_next = ST_SPIN;
               duty_next  = FULL_DUTY;
               phase_next = 4'h0;
            end
         end
         default: begin
            state_next = ST_OFF;
            duty_next  = 7'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state_reg <= START_OPT ? ST_WAIT : ST_OFF;
         duty_reg  <= 7'h00;
         phase_reg <= 4'h0;
      end else if (ce_i) begin
         state_reg <= state_next;
         duty_reg  <= duty_next;
         phase_reg <= phase_next;
      end
   end

   // ---------------- pwm generator ----------------
   // fixed 32 hz frame of 64 slots; duty 64 keeps the output high throughout
   logic [PW-1:0] slot_cyc_reg;
   logic [5:0]    slot_reg;
   logic          pwm_reg;
   wire           slot_end = slot_cyc_reg == PW'(SLOT_CYC - 1);

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         slot_cyc_reg <= '0;
         slot_reg     <= 6'h00;
         pwm_reg      <= 1'b0;
      end else if (ce_i) begin
         slot_cyc_reg <= slot_end ? '0 : slot_cyc_reg + PW'(1);
         if (slot_end) begin
            slot_reg <= slot_reg + 6'h01;
         end
         pwm_reg <= {1'b0, slot_reg} < duty_next;
      end
   end

   // ---------------- fan sense ----------------
   sense_mode_t mode_reg;
   logic        win_open_reg;
   logic [1:0]  win_secs_reg;
   wire         win_end = sec_tick && full_duty && win_open_reg &&
                          (win_secs_reg == 2'(FAULT_WIN_SECS - 1));
   wire         win_clr = !full_duty || (sec_tick && !win_open_reg) || win_end;
   wire  [1:0]  sense_raw = {fan_sense_in_b_i, fan_sense_in_a_i};
   logic [1:0]  ch_fail;

   // window opens on the first second boundary at full duty, so it spans exactly 2 s
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         win_open_reg <= 1'b0;
         win_secs_reg <= 2'h0;
      end else if (ce_i) begin
         if (!full_duty) begin
            win_open_reg <= 1'b0;
            win_secs_reg <= 2'h0;
         end else if (sec_tick) begin
            win_open_reg <= 1'b1;
            win_secs_reg <= (win_end || !win_open_reg) ? 2'h0 : win_secs_reg + 2'h1;
         end
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_sense
      logic [1:0] sync_reg;
      logic [1:0] hist_reg;
      logic       level_reg;
      logic [5:0] pulses_reg;
      logic       seen_high_reg;
      // a level must agree on two samples before it counts as an edge
      wire        stable_hi = hist_reg == 2'b11;
      wire        stable_lo = hist_reg == 2'b00;
      wire        rise      = stable_hi && !level_reg;

      always_ff @(posedge clk_sys_i) begin
         if (!nrst_i) begin
            sync_reg      <= 2'b11;
            hist_reg      <= 2'b11;
            level_reg     <= 1'b1;
            pulses_reg    <= 6'h00;
            seen_high_reg <= 1'b0;
         end else if (ce_i) begin
            sync_reg <= {sync_reg[0], sense_raw[c]};
            hist_reg <= {hist_reg[0], sync_reg[1]};
            if (stable_hi) begin
               level_reg <= 1'b1;
            end else if (stable_lo) begin
               level_reg <= 1'b0;
            end
            if (win_clr) begin
               pulses_reg    <= 6'h00;
               seen_high_reg <= 1'b0;
            end else if (win_open_reg) begin
               if (rise && pulses_reg != 6'(TACH_MIN_PULSES)) begin
                  pulses_reg <= pulses_reg + 6'h01;
               end
               if (level_reg) begin
                  seen_high_reg <= 1'b1;
               end
            end
         end
      end

      assign ch_fail[c] = (mode_reg == SENSE_TACH)   ? (pulses_reg < 6'(TACH_MIN_PULSES)) :
                          (mode_reg == SENSE_LOCKED) ? !seen_high_reg : 1'b0;
   end

   // ---------------- ahb-lite slave ----------------
   logic        fault_reg;
   logic        ap_wr_reg;
   logic [7:0]  ap_addr_reg;
   logic [31:0] rdata_reg;
   wire         ap_take  = hsel_i && hready_i && htrans_i[1];
   wire         wr_ctrl  = ap_wr_reg && (ap_addr_reg == CTRL_OFS);
   wire         sw_clear = wr_ctrl && hwdata_i[CTRL_CLEAR_BIT];
   wire  [31:0] ctrl_rd  = {30'h0, mode_reg};
   wire  [31:0] stat_rd  = {13'h0, full_duty, fault_reg, hot_reg,
                            6'h0, state_reg, 1'b0, duty_reg};
   wire  [31:0] temp_rd  = {alarm_limit, lower_fan_limit, upper_fan_limit, temp_reg};
   wire  [31:0] rd_mux   = (haddr_i == CTRL_OFS)   ? ctrl_rd :
                           (haddr_i == STATUS_OFS) ? stat_rd :
                           (haddr_i == TEMP_OFS)   ? temp_rd : 32'h0000_0000;

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ap_wr_reg   <= 1'b0;
         ap_addr_reg <= 8'h00;
         rdata_reg   <= 32'h0000_0000;
         mode_reg    <= CTRL_MODE_RST;
      end else if (ce_i) begin
         ap_wr_reg   <= ap_take && hwrite_i;
         ap_addr_reg <= haddr_i;
         if (ap_take && !hwrite_i) begin
            rdata_reg <= rd_mux;
         end
         if (wr_ctrl) begin
            mode_reg <= (hwdata_i[1:0] == 2'b11) ? SENSE_OFF : sense_mode_t'(hwdata_i[1:0]);
         end
      end
   end

   // a failing window wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         fault_reg <= 1'b0;
      end else if (ce_i) begin
         if (win_end && |ch_fail) begin
            fault_reg <= 1'b1;
         end else if (sw_clear) begin
            fault_reg <= 1'b0;
         end
      end
   end

   assign hreadyout_o            = 1'b1;
   assign hresp_o                = 1'b0;
   assign hrdata_o               = rdata_reg;
   assign pwm_out_o              = pwm_reg;
   assign overheat_alarm_n_o     = 1'b0;
   assign overheat_alarm_n_oe_o  = hot_reg;
   assign fan_fault_alarm_n_o    = 1'b0;
   assign fan_fault_alarm_n_oe_o = fault_reg;

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence s_run_eval;
      state_reg == ST_RUN && eval_tick;
   endsequence

   a_duty_cap: assert property (duty_reg <= FULL_DUTY)
      else $error("duty above 64 steps");
   a_step_up: assert property (s_run_eval and (above_upper && !full_duty) |=>
                               duty_reg == $past(duty_reg) + 7'h01)
      else $error("duty did not rise one step");
   a_step_down: assert property (s_run_eval and (!above_upper && below_lower &&
                                 duty_reg > FLOOR_D) |=> duty_reg == $past(duty_reg) - 7'h01)
      else $error("duty did not fall one step");
   a_dead_band: assert property (s_run_eval and (!above_upper && !below_lower) |=>
                                 $stable(duty_reg))
      else $error("duty moved inside dead band");
   a_hold_between: assert property (state_reg == ST_RUN && !eval_tick |=> $stable(duty_reg))
      else $error("duty moved outside an evaluation");
   a_floor_kept: assert property (state_reg == ST_RUN |-> duty_reg >= FLOOR_D)
      else $error("duty under minimum");
   a_spin_full: assert property (state_reg == ST_SPIN |-> duty_reg == FULL_DUTY)
      else $error("spin-up not at full duty");
   a_pwm_edges: assert property (duty_reg == FULL_DUTY && ce_i ##1 duty_reg == FULL_DUTY
                                 |-> pwm_out_o)
      else $error("pwm low at full duty");
   a_hot_set: assert property (sec_tick && temp_now > alarm_limit |=> overheat_alarm_n_oe_o)
      else $error("overheat alarm not asserted");
   a_fail_gate: assert property ($rose(fault_reg) |-> $past(full_duty))
      else $error("fault raised below full duty");
   a_short_zero: assert property (sec_tick && temp_a_bad_i && temp_b_bad_i |=>
                                  temp_reg == 8'h00)
      else $error("bad junctions not read as zero");
endmodule

/* File: testbench/fan_model.sv */
// fan with tachometer or locked-rotor sense lines, driven by the pwm output
module fan_model (
   // clock and drive
   input  wire logic clk_sys_i,
   input  wire logic pwm_i,
   input  wire logic stall_i,
   // sense lines
   output logic      sense_a_o,
   output logic      sense_b_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       powered_reg = 1'b0;
   logic [2:0] phase_reg   = 3'h0;
   // rotor turns only after it has seen drive; 3 high, 3 low survives deglitch
   always_ff @(posedge clk_sys_i) begin
      powered_reg <= powered_reg | pwm_i;
      phase_reg   <= (phase_reg == 3'h5) ? 3'h0 : phase_reg + 3'h1;
   end
   // a stalled fan stops pulsing and holds its locked-rotor flag low
   assign sense_a_o = powered_reg && !stall_i && (phase_reg < 3'h3);
   assign sense_b_o = powered_reg && !stall_i && (phase_reg >= 3'h2) && (phase_reg < 3'h5);
endmodule

/* File: testbench/thermal_fan_duty_controller_tb.sv */
// self-checking bench for the thermal fan duty controller
module thermal_fan_duty_controller_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fan_ctrl_pkg::*;
   localparam int unsigned SEC   = 128;
   localparam int unsigned SLOT  = 1;
   localparam int unsigned START = 19;
   logic        clk_sys_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [7:0]  haddr     = 8'h00;
   logic [1:0]  htrans    = 2'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [7:0]  ta        = 8'h00;
   logic [7:0]  tb        = 8'h00;
   logic        ta_bad    = 1'b0;
   logic        tb_bad    = 1'b0;
   logic [11:0] sel       = 12'h000;
   logic        stall     = 1'b0;
   logic        rd_pend   = 1'b0;
   logic        ready, hresp, pwm, pwm2, ot_n, ot_oe, ff_n, ff_oe, sa, sb;
   logic [31:0] hrdata;
   logic [31:0] s;
   logic [63:0] notes [$];
   int          err_count = 0;
   int          tests_run = 0;
   wire         ot_pin    = ot_oe ? ot_n : 1'b1;
   wire         ff_pin    = ff_oe ? ff_n : 1'b1;

   thermal_fan_duty_controller #(.SEC_CYC(SEC), .SLOT_CYC(SLOT), .WAIT_SECS(2),
      .SPIN_SECS(3), .START_OPT(1'b0), .START_DUTY(START)) uut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(ready), .hreadyout_o(ready),
      .hresp_o(hresp), .hrdata_o(hrdata),
      .temp_a_i(ta), .temp_a_bad_i(ta_bad), .temp_b_i(tb), .temp_b_bad_i(tb_bad),
      .upper_limit_sel_hi_i(sel[11:10]), .upper_limit_sel_lo_i(sel[9:8]),
      .lower_limit_sel_hi_i(sel[7:6]), .lower_limit_sel_lo_i(sel[5:4]),
      .alarm_limit_sel_hi_i(sel[3:2]), .alarm_limit_sel_lo_i(sel[1:0]),
      .fan_sense_in_a_i(sa), .fan_sense_in_b_i(sb), .pwm_out_o(pwm),
      .overheat_alarm_n_o(ot_n), .overheat_alarm_n_oe_o(ot_oe),
      .fan_fault_alarm_n_o(ff_n), .fan_fault_alarm_n_oe_o(ff_oe));

   fan_model fan (.clk_sys_i(clk_sys_i), .pwm_i(pwm), .stall_i(stall),
      .sense_a_o(sa), .sense_b_o(sb));

   // start-duty option, judged on its drive pin only
   thermal_fan_duty_controller #(.SEC_CYC(SEC), .SLOT_CYC(SLOT), .WAIT_SECS(2),
      .SPIN_SECS(3), .START_OPT(1'b1), .START_DUTY(START)) uut_start (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .hsel_i(1'b0), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(ready), .hreadyout_o(),
      .hresp_o(), .hrdata_o(),
      .temp_a_i(ta), .temp_a_bad_i(ta_bad), .temp_b_i(tb), .temp_b_bad_i(tb_bad),
      .upper_limit_sel_hi_i(sel[11:10]), .upper_limit_sel_lo_i(sel[9:8]),
      .lower_limit_sel_hi_i(sel[7:6]), .lower_limit_sel_lo_i(sel[5:4]),
      .alarm_limit_sel_hi_i(sel[3:2]), .alarm_limit_sel_lo_i(sel[1:0]),
      .fan_sense_in_a_i(sa), .fan_sense_in_b_i(sb), .pwm_out_o(pwm2),
      .overheat_alarm_n_o(), .overheat_alarm_n_oe_o(),
      .fan_fault_alarm_n_o(), .fan_fault_alarm_n_oe_o());

   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic conclude;
      if (err_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // read notes carry {mask, expected}; mask zero means a plain poll
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] m, input logic [31:0] e, output logic [31:0] rdv);
      @(posedge clk_sys_i);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys_i); while (ready !== 1'b1);
      if (!w) notes.push_back({m, e});
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys_i); while (ready !== 1'b1);
      rdv = hrdata;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      xfer(1'b0, a, 32'h0, m, e, d);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      xfer(1'b1, a, wd, 32'h0, 32'h0, d);
   endtask

   task automatic stat(output logic [31:0] v);
      xfer(1'b0, STATUS_OFS, 32'h0, 32'h0, 32'h0, v);
   endtask

   task automatic secs(input int n);
      repeat (n * SEC + 4) @(posedge clk_sys_i);
   endtask

   task automatic wait_state(input logic [1:0] st);
      s = 32'h0;
      for (int k = 0; k < 600 && s[9:8] !== st; k++) stat(s);
   endtask

   // every observed duty change must be a single step towards the target
   task automatic step_to(input int target);
      int prev;
      stat(s);
      prev = int'(s[6:0]);
      while (prev != target) begin
         for (int k = 0; k < 400 && int'(s[6:0]) == prev; k++) stat(s);
         prev = (target > prev) ? prev + 1 : prev - 1;
         chk(32'(s[6:0]), 32'(prev));
      end
   endtask

   // one full frame of the chosen drive pin; opt picks the start-duty unit
   task automatic pwm_cnt(input bit opt, input int exp);
      int c;
      c = 0;
      repeat (64 * SLOT) @(posedge clk_sys_i) if ((opt ? pwm2 : pwm) === 1'b1) c++;
      chk(32'(c), 32'(exp));
   endtask

   // read results are judged here, in bus order
   always @(posedge clk_sys_i) begin
      if (rd_pend && ready === 1'b1 && notes.size() > 0) cmp_rd(notes.pop_front());
      if (ready === 1'b1) rd_pend <= hsel && htrans[1] && !hwrite;
   end

   task automatic cmp_rd(input logic [63:0] n);
      if (n[63:32] != 32'h0) chk(hrdata & n[63:32], n[31:0]);
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys_i);
      err_count++;
      conclude();
   end

   initial begin
      void'($urandom(32460));
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      chk(32'(pwm), 32'h0);
      // start-duty unit waits two seconds at zero drive
      pwm_cnt(1'b1, 0);
      rd(CTRL_OFS, 32'hffffffff, 32'h0);
      rd(STATUS_OFS, 32'hffffffff, 32'h300);
      for (int c = 0; c < 9; c++) begin
         sel <= {3{2'(c / 3), 2'(c % 3)}};
         repeat (4) @(posedge clk_sys_i);
         rd(TEMP_OFS, 32'hffffff00, {8'(60 + 5 * c), 8'(15 + 5 * c), 8'(20 + 5 * c), 8'h00});
      end
      sel <= {3{2'h1, 2'h1}};
      ta <= 8'($urandom_range(30));
      tb <= 8'($urandom_range(30));
      secs(1);
      rd(TEMP_OFS, 32'hff, 32'((ta > tb) ? ta : tb));
      ta_bad <= 1'b1;
      ta <= 8'h5a;
      secs(1);
      rd(TEMP_OFS, 32'hff, 32'(tb));
      chk(32'(ot_pin), 32'h1);
      // about 400 cycles in: start-duty unit is inside its 3 s spin-up
      pwm_cnt(1'b1, 64);
      tb_bad <= 1'b1;
      secs(5);
      rd(TEMP_OFS, 32'hff, 32'h0);
      rd(STATUS_OFS, 32'h37f, 32'h300);
      {ta_bad, tb_bad} <= 2'b00;
      ta <= 8'h51;
      secs(1);
      chk(32'(ot_pin), 32'h0);
      wait_state(2'h1);
      chk(32'(s[6:0]), 32'h40);
      wait_state(2'h2);
      chk(32'(s[6:0]), 32'(START));
      pwm_cnt(1'b0, START * SLOT);
      stall <= 1'b1;
      ta <= 8'h50;
      secs(1);
      chk(32'(ot_pin), 32'h0);
      ta <= 8'h3c;
      secs(1);
      chk(32'(ot_pin), 32'h1);
      secs(3);
      chk(32'(ff_pin), 32'h1);
      stall <= 1'b0;
      step_to(START + 4);
      ta <= 8'h25;
      stat(s);
      secs(5);
      rd(STATUS_OFS, 32'h7f, 32'(s[6:0]));
      ta <= 8'h3c;
      step_to(64);
      secs(5);
      rd(STATUS_OFS, 32'h4007f, 32'h40040);
      pwm_cnt(1'b0, 64 * SLOT);
      chk(32'(ff_pin), 32'h1);
      for (int m = 0; m < 2; m++) begin
         wr(CTRL_OFS, 32'(m));
         rd(CTRL_OFS, 32'h3, 32'(m));
         stall <= 1'b1;
         secs(5);
         chk(32'(ff_pin), 32'h0);
         rd(STATUS_OFS, 32'h20000, 32'h20000);
         stall <= 1'b0;
         secs(3);
         wr(CTRL_OFS, 32'(m) | 32'h100);
         rd(CTRL_OFS, 32'h103, 32'(m));
         secs(5);
         chk(32'(ff_pin), 32'h1);
      end
      wr(CTRL_OFS, 32'h3);
      rd(CTRL_OFS, 32'h3, 32'h2);
      stall <= 1'b1;
      secs(5);
      chk(32'(ff_pin), 32'h1);
      stall <= 1'b0;
      wr(TEMP_OFS, 32'hffffffff);
      rd(TEMP_OFS, 32'hffffff00, 32'h50232800);
      wr(8'h0c, 32'hffffffff);
      rd(8'h0c, 32'hffffffff, 32'h0);
      chk(32'(hresp), 32'h0);
      ta <= 8'($urandom_range(34));
      tb <= 8'($urandom_range(34));
      step_to(0);
      rd(STATUS_OFS, 32'h37f, 32'h300);
      secs(5);
      rd(STATUS_OFS, 32'h37f, 32'h300);
      // start-duty unit went down with it but must stop at its floor
      pwm_cnt(1'b1, START * SLOT);
      conclude();
   end
endmodule
